// ### verilog/pcter_pkg.sv
package pcter_pkg;

  // ----------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_INT_PIN      = 8'h3d;
  localparam logic [7:0]  OFS_MIN_GNT      = 8'h3e;
  localparam logic [7:0]  OFS_MAX_LAT      = 8'h3f;
  localparam logic [7:0]  OFS_RELEASE      = 8'h60;
  localparam logic [7:0]  OFS_FRAME_ADJ    = 8'h61;
  localparam logic [7:0]  OFS_WAKE_MASK    = 8'h62;

  // dword indices of the two configuration words
  localparam logic [5:0]  IDX_TAIL         = OFS_INT_PIN[7:2];
  localparam logic [5:0]  IDX_EHCI         = OFS_RELEASE[7:2];

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  INT_PIN_RST      = 8'h01;
  localparam logic [7:0]  MIN_GNT_RST_FS   = 8'h01;
  localparam logic [7:0]  MIN_GNT_RST_HS   = 8'h02;
  localparam logic [7:0]  MAX_LAT_RST_FS   = 8'h2a;
  localparam logic [7:0]  MAX_LAT_RST_HS   = 8'h10;
  localparam logic [7:0]  RELEASE_VAL      = 8'h20;
  localparam logic [7:0]  FRAME_ADJ_RST    = 8'h20;
  localparam logic [7:0]  FRAME_ADJ_MASK   = 8'h3f;
  localparam int          FRAME_ADJ_W      = 6;
  localparam logic [15:0] WAKE_MASK_RST    = 16'h001f;
  localparam logic [7:0]  FULL_MASK        = 8'hff;

  // interrupt pin encodings
  localparam logic [7:0]  INT_PIN_NONE     = 8'h00;
  localparam logic [7:0]  INT_PIN_A        = 8'h01;
  localparam logic [7:0]  INT_PIN_D        = 8'h04;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          SYS_CLK_MHZ      = 40;
  localparam int          SYS_CLK_NS       = 25;
  localparam int          HS_CLK_MHZ       = 480;
  localparam int          HS_PER_CLK       = HS_CLK_MHZ / SYS_CLK_MHZ;
  localparam int          GRANT_UNIT_NS    = 250;
  localparam int          GRANT_UNIT_CLKS  = GRANT_UNIT_NS / SYS_CLK_NS;
  localparam int          SOF_BASE         = 59488;
  localparam int          SOF_STEP         = 16;

endpackage

// ### verilog/pcter_frame_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcter_frame_if;
  logic [5:0]  frame_adj;
  logic        sof_pulse;
  logic [15:0] sof_length;

  modport regs  (output frame_adj, input sof_pulse, input sof_length);
  modport timer (input frame_adj, output sof_pulse, output sof_length);
endinterface

`default_nettype wire

// ### verilog/pcter_byte_reg.sv
`timescale 1ns/1ps
`default_nettype none

module pcter_byte_reg
  import pcter_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // contents
  output logic      [7:0] value
);

  logic [7:0] value_ff;

  // ------------------------------------------------------------
  // storage; masked bits keep their reset value
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_ff <= RST_VAL;
    end else if (wr_en) begin
      value_ff <= (value_ff & ~WR_MASK) | (wr_data & WR_MASK);
    end
  end

  assign value = value_ff;

endmodule

`default_nettype wire

// ### verilog/pcter_sof_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pcter_sof_timer
  import pcter_pkg::*;
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // frame control
  pcter_frame_if.timer frm
);

  logic [16:0] acc_ff;
  logic [15:0] len_ff;
  logic        sof_ff;
  logic [16:0] nxt_acc;
  logic [15:0] nxt_len;

  // ------------------------------------------------------------
  // high-speed bit times accumulate at the system clock rate
  // ------------------------------------------------------------
  always_comb begin
    nxt_len = 16'(SOF_BASE + SOF_STEP * int'(frm.frame_adj));
    nxt_acc = acc_ff + 17'(HS_PER_CLK);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 17'h00000;
      len_ff <= 16'(SOF_BASE + SOF_STEP * int'(FRAME_ADJ_RST));
      sof_ff <= 1'b0;
    end else if (nxt_acc >= {1'b0, len_ff}) begin
      acc_ff <= nxt_acc - {1'b0, len_ff};
      len_ff <= nxt_len;
      sof_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      sof_ff <= 1'b0;
    end
  end

  assign frm.sof_pulse  = sof_ff;
  assign frm.sof_length = len_ff;

endmodule

`default_nettype wire

// ### verilog/pcter_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - interrupt pin select is 8-bit read/write, resets to 01h (first line).
// - pin codes 1..4 select lines A..D; zero means no interrupt pin.
// - minimum grant and maximum latency count in 250 ns units.
// - zero in both grant and latency means no latency demand.
// - minimum grant 8-bit read/write, resets 01h full-speed, 02h enhanced.
// - maximum latency 8-bit read/write, resets 2ah full-speed, 10h enhanced.
// - only enhanced function has release, frame adjust and wake mask words.
// - release number is read-only and always reads 20h.
// - new frame adjust value changes following start-of-frame intervals.
// - frame adjust bits 7..6 read zero; field resets to 20h.
// - frame length is 59488 plus 16 per step, in 480 MHz periods.
module pcter_cfg_regs
  import pcter_pkg::*;
#(
  parameter bit IS_ENHANCED = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // configuration access
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [5:0]  cfg_idx,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic      [31:0] cfg_rdata,
  // function settings
  output logic      [3:0]  int_line_sel,
  output logic      [11:0] min_grant_cycles,
  output logic      [11:0] max_latency_cycles,
  output logic             latency_demand,
  output logic      [15:0] port_wake_capability_mask,
  // frame timing
  output logic             sof_pulse,
  output logic      [15:0] sof_length
);

  localparam logic [7:0] MIN_GNT_RST = IS_ENHANCED ? MIN_GNT_RST_HS : MIN_GNT_RST_FS;
  localparam logic [7:0] MAX_LAT_RST = IS_ENHANCED ? MAX_LAT_RST_HS : MAX_LAT_RST_FS;

  logic [1:0]  rst_sync_ff;
  logic        rst_int_n;
  logic        wr_tail;
  logic        wr_ehci;
  logic        hit_ehci;
  logic [7:0]  interrupt_pin_select;
  logic [7:0]  minimum_grant_time;
  logic [7:0]  maximum_latency_time;
  logic [7:0]  frame_length_adjust;
  logic [7:0]  wake_lo;
  logic [7:0]  wake_hi;
  logic [31:0] nxt_rdata;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [3:0]  line_ff;
  logic [11:0] grant_ff;
  logic [11:0] latency_ff;
  logic        demand_ff;

  pcter_frame_if frm ();

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign hit_ehci = IS_ENHANCED && (cfg_idx == IDX_EHCI);
  assign wr_tail  = cfg_req && cfg_we && (cfg_idx == IDX_TAIL);
  assign wr_ehci  = cfg_req && cfg_we && hit_ehci;

  // ----------------------------------------------------------------
  // header tail registers
  // ----------------------------------------------------------------
  pcter_byte_reg #(.RST_VAL(INT_PIN_RST), .WR_MASK(FULL_MASK)) u_int_pin (
    .clk     (sys_clk),
    .rst_n   (rst_int_n),
    .wr_en   (wr_tail && cfg_be[1]),
    .wr_data (cfg_wdata[15:8]),
    .value   (interrupt_pin_select)
  );

  pcter_byte_reg #(.RST_VAL(MIN_GNT_RST), .WR_MASK(FULL_MASK)) u_min_gnt (
    .clk     (sys_clk),
    .rst_n   (rst_int_n),
    .wr_en   (wr_tail && cfg_be[2]),
    .wr_data (cfg_wdata[23:16]),
    .value   (minimum_grant_time)
  );

  pcter_byte_reg #(.RST_VAL(MAX_LAT_RST), .WR_MASK(FULL_MASK)) u_max_lat (
    .clk     (sys_clk),
    .rst_n   (rst_int_n),
    .wr_en   (wr_tail && cfg_be[3]),
    .wr_data (cfg_wdata[31:24]),
    .value   (maximum_latency_time)
  );

  // ----------------------------------------------------------------
  // enhanced function registers
  // ----------------------------------------------------------------
  pcter_byte_reg #(.RST_VAL(FRAME_ADJ_RST), .WR_MASK(FRAME_ADJ_MASK)) u_frame_adj (
    .clk     (sys_clk),
    .rst_n   (rst_int_n),
    .wr_en   (wr_ehci && cfg_be[1]),
    .wr_data (cfg_wdata[15:8]),
    .value   (frame_length_adjust)
  );

  pcter_byte_reg #(.RST_VAL(WAKE_MASK_RST[7:0]), .WR_MASK(FULL_MASK)) u_wake_lo (
    .clk     (sys_clk),
    .rst_n   (rst_int_n),
    .wr_en   (wr_ehci && cfg_be[2]),
    .wr_data (cfg_wdata[23:16]),
    .value   (wake_lo)
  );

  pcter_byte_reg #(.RST_VAL(WAKE_MASK_RST[15:8]), .WR_MASK(FULL_MASK)) u_wake_hi (
    .clk     (sys_clk),
    .rst_n   (rst_int_n),
    .wr_en   (wr_ehci && cfg_be[3]),
    .wr_data (cfg_wdata[31:24]),
    .value   (wake_hi)
  );

  // ----------------------------------------------------------------
  // start-of-frame timer
  // ----------------------------------------------------------------
  assign frm.frame_adj = frame_length_adjust[FRAME_ADJ_W-1:0];

  pcter_sof_timer u_sof (
    .clk   (sys_clk),
    .rst_n (rst_int_n),
    .frm   (frm)
  );

  assign sof_pulse  = frm.sof_pulse;
  assign sof_length = frm.sof_length;

  // ----------------------------------------------------------------
  // read mux; unmapped words and byte 0x3c return nothing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (cfg_idx == IDX_TAIL) begin
      nxt_rdata = {maximum_latency_time, minimum_grant_time, interrupt_pin_select, 8'h00};
    end else if (hit_ehci) begin
      nxt_rdata = {wake_hi, wake_lo, frame_length_adjust, RELEASE_VAL};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= cfg_req;
      if (cfg_req && !cfg_we) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign cfg_ack   = ack_ff;
  assign cfg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // settings presented to the function
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      line_ff <= 4'h1;
    end else if ((interrupt_pin_select >= INT_PIN_A) && (interrupt_pin_select <= INT_PIN_D)) begin
      line_ff <= 4'(4'h1 << (interrupt_pin_select[1:0] - 2'h1));
    end else begin
      line_ff <= 4'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      grant_ff   <= 12'(int'(MIN_GNT_RST) * GRANT_UNIT_CLKS);
      latency_ff <= 12'(int'(MAX_LAT_RST) * GRANT_UNIT_CLKS);
    end else begin
      grant_ff   <= 12'(int'(minimum_grant_time) * GRANT_UNIT_CLKS);
      latency_ff <= 12'(int'(maximum_latency_time) * GRANT_UNIT_CLKS);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      demand_ff <= 1'b1;
    end else begin
      demand_ff <= (minimum_grant_time != 8'h00) || (maximum_latency_time != 8'h00);
    end
  end

  assign int_line_sel              = line_ff;
  assign min_grant_cycles          = grant_ff;
  assign max_latency_cycles        = latency_ff;
  assign latency_demand            = demand_ff;
  assign port_wake_capability_mask = IS_ENHANCED ? {wake_hi, wake_lo} : 16'h0000;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [12:0] gap_ff;

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      gap_ff <= 13'h0000;
    end else if (frm.sof_pulse) begin
      gap_ff <= 13'h0001;
    end else if (gap_ff != 13'h1fff && gap_ff != 13'h0000) begin
      gap_ff <= gap_ff + 13'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_int_n);

  a_ack_one_cycle: assert property (cfg_req |=> cfg_ack)
    else $error("config access not acknowledged");

  a_pin_write: assert property (wr_tail && cfg_be[1] |=> interrupt_pin_select == $past(cfg_wdata[15:8]))
    else $error("interrupt pin select not written");

  a_pin_decode: assert property (interrupt_pin_select == INT_PIN_A |=> int_line_sel == 4'h1)
    else $error("interrupt pin code not decoded");

  a_pin_none: assert property (interrupt_pin_select == INT_PIN_NONE |=> int_line_sel == 4'h0)
    else $error("zero pin code still selects a line");

  a_grant_units: assert property (1'b1 |=> min_grant_cycles == 12'(int'($past(minimum_grant_time)) * 10))
    else $error("grant time not in 250 ns units");

  a_no_demand: assert property (minimum_grant_time == 8'h00 && maximum_latency_time == 8'h00 |=> !latency_demand)
    else $error("zero grant and latency still demand");

  a_release_fixed: assert property (cfg_req && !cfg_we && hit_ehci |=> cfg_rdata[7:0] == 8'h20)
    else $error("release number not 20h");

  a_adj_reserved: assert property (cfg_req && !cfg_we && hit_ehci |=> cfg_rdata[15:14] == 2'b00)
    else $error("frame adjust reserved bits not zero");

  a_unmapped_zero: assert property (cfg_req && !cfg_we && cfg_idx != IDX_TAIL && !hit_ehci
                                    |=> cfg_rdata == 32'h0)
    else $error("unmapped word reads nonzero");

  a_sof_length: assert property (frm.sof_pulse
                                 |-> sof_length == 16'(59488 + 16 * int'($past(frm.frame_adj))))
    else $error("frame length not base plus 16 per step");

  a_sof_spacing: assert property (frm.sof_pulse && gap_ff != 13'h0000 && $stable(frm.frame_adj)
                                  |-> (int'(gap_ff) * 12 >= int'($past(sof_length)) - 12)
                                   && (int'(gap_ff) * 12 <= int'($past(sof_length)) + 12))
    else $error("frame spacing does not match length");

  a_latency_units: assert property (1'b1 |=>
                                    max_latency_cycles == 12'(int'($past(maximum_latency_time)) * 10))
    else $error("latency time not in 250 ns units");

  a_grant_write: assert property (wr_tail && cfg_be[2] |=> minimum_grant_time == $past(cfg_wdata[23:16]))
    else $error("minimum grant not written");

  a_lat_write: assert property (wr_tail && cfg_be[3] |=> maximum_latency_time == $past(cfg_wdata[31:24]))
    else $error("maximum latency not written");

  a_adj_write: assert property (wr_ehci && cfg_be[1]
                                |=> frame_length_adjust == {2'b00, $past(cfg_wdata[13:8])})
    else $error("frame adjust write not masked to six bits");

  a_pin_keep: assert property (!(wr_tail && cfg_be[1]) |=> $stable(interrupt_pin_select))
    else $error("interrupt pin select changed without a write");

  a_pin_range: assert property (interrupt_pin_select > INT_PIN_D |=> int_line_sel == 4'h0)
    else $error("out of range pin code selects a line");

  a_demand_on: assert property (minimum_grant_time != 8'h00 || maximum_latency_time != 8'h00
                                |=> latency_demand)
    else $error("nonzero grant or latency shows no demand");

  a_ehci_keep: assert property (!IS_ENHANCED |=> $stable({wake_hi, wake_lo, frame_length_adjust}))
    else $error("full-speed function stored enhanced registers");

  a_reset_restore: assert property ($rose(rst_int_n)
                                    |-> interrupt_pin_select == INT_PIN_RST && minimum_grant_time == MIN_GNT_RST
                                     && maximum_latency_time == MAX_LAT_RST && frame_length_adjust == FRAME_ADJ_RST
                                     && {wake_hi, wake_lo} == WAKE_MASK_RST)
    else $error("registers not at reset values after bus reset");

  c_adj_write: cover property (wr_ehci && cfg_be[1]);
  c_sof_seen:  cover property (frm.sof_pulse && gap_ff != 13'h0000);
  c_tail_read: cover property (cfg_req && !cfg_we && cfg_idx == IDX_TAIL);
  c_pin_none:  cover property (interrupt_pin_select == INT_PIN_NONE);
  c_pin_range: cover property (interrupt_pin_select > INT_PIN_D);

endmodule

`default_nettype wire

// ### tb/pcter_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// host bridge issuing configuration cycles
// ----------------------------------------------------------------
module pcter_host_model (
  // clock
  input  wire logic        clk,
  // configuration bus
  output logic             cfg_req,
  output logic             cfg_we,
  output logic      [5:0]  cfg_idx,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  // status
  output logic             stuck
);
  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_idx   = 6'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
    stuck     = 1'b0;
  end

  // request and qualifiers held until ack is sampled high or 8 clocks pass, then request and byte enables cleared, index and data inverted
  task automatic access(input logic we, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk);
    cfg_req   <= 1'b1;
    cfg_we    <= we;
    cfg_idx   <= idx;
    cfg_be    <= be;
    cfg_wdata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cfg_ack !== 1'b1 && n < 8);
    stuck = (cfg_ack !== 1'b1);
    rd = cfg_rdata;
    cfg_req   <= 1'b0;
    cfg_be    <= 4'h0;
    cfg_idx   <= ~idx;
    cfg_wdata <= ~wd;
  endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pcter_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk;
  logic        rst_n = 1'b0;
  logic        cfg_req, cfg_we, cfg_ack;
  logic [5:0]  cfg_idx;
  logic [3:0]  cfg_be, int_line_sel;
  logic [31:0] cfg_wdata, cfg_rdata, rdata_fs;
  logic [11:0] min_grant_cycles, max_latency_cycles;
  logic        latency_demand, sof_pulse;
  logic [15:0] port_wake_capability_mask, sof_length;
  int          failures = 0;
  int          tests_run = 0;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  pcter_host_model host (.clk(sys_clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .stuck());

  pcter_cfg_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_idx(cfg_idx), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .int_line_sel(int_line_sel), .min_grant_cycles(min_grant_cycles),
    .max_latency_cycles(max_latency_cycles), .latency_demand(latency_demand),
    .port_wake_capability_mask(port_wake_capability_mask), .sof_pulse(sof_pulse),
    .sof_length(sof_length));

  pcter_cfg_regs #(.IS_ENHANCED(1'b0)) dut_fs (.sys_clk(sys_clk), .rst_n(rst_n),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(), .cfg_rdata(rdata_fs), .int_line_sel(),
    .min_grant_cycles(), .max_latency_cycles(), .latency_demand(),
    .port_wake_capability_mask(), .sof_pulse(), .sof_length());

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic check_near(input string what, input int exp, input int got);
    tests_run++;
    if (got < exp - 1 || got > exp + 1) begin
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      failures++;
    end
  endtask

  task automatic cfg(input logic we, input logic [5:0] idx, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd);
    host.access(we, idx, be, wd, rd);
    if (host.stuck !== 1'b0) begin
      $display("[ERR] cfg_ack expected 1 seen %b", cfg_ack);
      failures++;
      complete_run();
    end
  endtask

  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (sof_pulse !== 1'b1 && n < 6000);
    if (sof_pulse !== 1'b1) begin
      $display("[ERR] sof_pulse expected 1 seen %b", sof_pulse);
      failures++;
      complete_run();
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [31:0] rd;
    cfg(1'b0, IDX_TAIL, 4'hf, 32'h0, rd);
    check("tail word", {MAX_LAT_RST_HS, MIN_GNT_RST_HS, INT_PIN_RST, 8'h00}, rd);
    check("tail word fs", {MAX_LAT_RST_FS, MIN_GNT_RST_FS, INT_PIN_RST, 8'h00}, rdata_fs);
    cfg(1'b0, IDX_EHCI, 4'hf, 32'h0, rd);
    check("ehci word", {WAKE_MASK_RST, FRAME_ADJ_RST, RELEASE_VAL}, rd);
    check("ehci word fs", 32'h0, rdata_fs);
    check("wake mask", 32'(WAKE_MASK_RST), 32'(port_wake_capability_mask));
    check("pin one-hot", 32'h1, 32'(int_line_sel));
    check("grant", MIN_GNT_RST_HS * GRANT_UNIT_CLKS, 32'(min_grant_cycles));
    check("latency", MAX_LAT_RST_HS * GRANT_UNIT_CLKS, 32'(max_latency_cycles));
    check("frame length", SOF_BASE + SOF_STEP * 32, 32'(sof_length));
  endtask

  task automatic t_int_pin();
    logic [31:0] rd;
    logic [31:0] exp;
    for (int c = 0; c < 6; c++) begin
      cfg(1'b1, IDX_TAIL, 4'h2, {16'h0, 8'(c), 8'h00}, rd);
      cfg(1'b0, IDX_TAIL, 4'hf, 32'h0, rd);
      check("pin readback", 32'(c), 32'(rd[15:8]));
      exp = (c >= 1 && c <= 4) ? (32'h1 << (c - 1)) : 32'h0;
      check("pin one-hot", exp, 32'(int_line_sel));
    end
  endtask

  task automatic t_grant_latency();
    logic [31:0] rd;
    logic [7:0]  g [4] = '{8'h03, 8'h00, 8'h01, 8'h00};
    logic [7:0]  l [4] = '{8'hff, 8'h00, 8'h00, 8'h05};
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, IDX_TAIL, 4'hc, {l[i], g[i], 16'h0}, rd);
      repeat (2) @(posedge sys_clk);
      check("grant", g[i] * GRANT_UNIT_CLKS, 32'(min_grant_cycles));
      check("latency", l[i] * GRANT_UNIT_CLKS, 32'(max_latency_cycles));
      check("demand", 32'((g[i] | l[i]) != 8'h00), 32'(latency_demand));
    end
  endtask

  task automatic t_readonly();
    logic [31:0] rd;
    cfg(1'b1, IDX_EHCI, 4'hf, 32'hffff_ffff, rd);
    cfg(1'b0, IDX_EHCI, 4'hf, 32'h0, rd);
    check("ehci word", {16'hffff, FRAME_ADJ_MASK, RELEASE_VAL}, rd);
    check("ehci word fs", 32'h0, rdata_fs);
    check("wake mask", 32'h0000ffff, 32'(port_wake_capability_mask));
    cfg(1'b1, IDX_TAIL, 4'h1, 32'h0000_00aa, rd);
    cfg(1'b0, IDX_TAIL, 4'hf, 32'h0, rd);
    check("tail byte0", 32'h0, 32'(rd[7:0]));
    cfg(1'b1, 6'h3f, 4'hf, 32'hffff_ffff, rd);
    cfg(1'b0, 6'h3f, 4'hf, 32'h0, rd);
    check("unmapped", 32'h0, rd);
  endtask

  task automatic t_frame();
    logic [31:0] rd;
    int          n;
    int          sum;
    cfg(1'b1, IDX_EHCI, 4'h2, 32'h0, rd);
    wait_pulse(n);
    sum = 0;
    for (int i = 0; i < 3; i++) begin
      wait_pulse(n);
      sum += n;
    end
    check_near("three frames adj 0", 3 * SOF_BASE / HS_PER_CLK, sum);
    check("length adj 0", SOF_BASE, 32'(sof_length));
    cfg(1'b1, IDX_EHCI, 4'h2, 32'h0000_3f00, rd);
    check("length mid-frame", SOF_BASE, 32'(sof_length));
    wait_pulse(n);
    sum = 0;
    for (int i = 0; i < 3; i++) begin
      wait_pulse(n);
      sum += n;
    end
    check_near("three frames adj 3f", 3 * (SOF_BASE + SOF_STEP * 63) / HS_PER_CLK, sum);
    check("length adj 3f", SOF_BASE + SOF_STEP * 63, 32'(sof_length));
  endtask

  initial begin
    do_reset();
    t_reset_values();
    t_int_pin();
    t_grant_latency();
    t_readonly();
    t_frame();
    do_reset();
    t_reset_values();
    complete_run();
  end
endmodule

`default_nettype wire
